// [rtl/rpc_core.sv]
// resolver position scaling, velocity and cyclic input image
//
// Contract
// [RULE1] direction select 0 counts clockwise up
// [RULE2] scaling off: native 65536 counts per turn
// [RULE3] scaling on: counts-per-turn counts per revolution
// [RULE4] counts per turn 1..65536, velocity basis
// [RULE5] position returns to zero at wrap count
// [RULE6] wrap count zero or 2..variant maximum
// [RULE7] velocity unit chosen by four codes
// [RULE8] image eight bytes plain, twenty synced
// [RULE9] no connection without valid configuration
// [RULE10] scanner pushes whole configuration on open
// [RULE11] image refreshed every packet interval
// [RULE12] plain image: position word, velocity word
// [RULE13] controller commands by explicit messages only
// [RULE14] wrap zero counts full native range
`timescale 1ns/1ps
`default_nettype none
module rpc_core
  import rpc_pkg::*;
#(
  parameter int unsigned POS_BITS   = RPC_POS_BITS,
  parameter int unsigned RPI_CYCLES = RPC_RPI_CYCLES
) (
  input  wire logic        mclk,
  input  wire logic        rstn,
  input  wire logic        cfg_wr,
  input  wire rpc_cfg_t    cfg_in,
  input  wire logic        conn_open,
  input  wire logic        conn_close,
  input  wire logic        time_sync_fmt,
  input  wire logic [95:0] sync_data,
  input  wire logic        angle_valid,
  input  wire logic [15:0] angle,
  output logic             cfg_ok,
  output logic             conn_up,
  output logic             conn_refused,
  output logic [31:0]      position,
  output logic [31:0]      velocity,
  output rpc_word_t        img_word,
  output logic             img_valid,
  input  wire logic        img_ready
);
  ////////////////////////////////////////////////////////////////////////
  // configuration and connection
  rpc_cfg_t    cfg_q;
  logic        cfg_ok_q;
  logic        conn_up_q;
  logic        refused_q;
  logic [32:0] range_max;
  logic        cfg_in_ok;

  assign range_max = 33'h1_0000_0000 >> (32 - POS_BITS);
  assign cfg_in_ok = (cfg_in.cpt >= RPC_CPT_MIN) && (cfg_in.cpt <= RPC_CPT_MAX)          // RULE4
                  && ((cfg_in.wrap == 32'h0) || ((cfg_in.wrap >= RPC_WRAP_MIN)
                  && ({1'b0, cfg_in.wrap} <= range_max)))                                  // RULE6
                  && ((cfg_in.vel_unit == RPC_VU_PPS) || (cfg_in.vel_unit == RPC_VU_PPMS)
                  || (cfg_in.vel_unit == RPC_VU_PPMIN) || (cfg_in.vel_unit == RPC_VU_RPM)); // RULE7
  wire open_ok  = conn_open && cfg_ok_q && !conn_up_q;   // RULE9
  wire open_bad = conn_open && !cfg_ok_q;                // RULE9

  // config store; an invalid push drops the link
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cfg_q     <= '0;
      cfg_ok_q  <= 1'b0;
      conn_up_q <= 1'b0;
      refused_q <= 1'b0;
    end else begin
      if (cfg_wr) begin
        cfg_q    <= cfg_in;        // RULE10
        cfg_ok_q <= cfg_in_ok;
      end
      conn_up_q <= (conn_up_q || open_ok) && !conn_close && !(cfg_wr && !cfg_in_ok); // RULE9
      refused_q <= open_bad;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // position scaling and wrap
  logic        [32:0] range_w;
  logic signed [16:0] delta;
  logic signed [17:0] eff_cpt;
  logic signed [35:0] frac_sum;
  logic signed [35:0] step;
  logic signed [35:0] pos_sum;
  logic signed [35:0] pos_fix;
  logic        [15:0] prev_q;
  logic        [15:0] rem_q;
  logic        [31:0] pos_q;
  logic               seen_q;
  logic signed [31:0] nat_acc_q;
  wire                adv = angle_valid && cfg_ok_q && seen_q;

  assign range_w  = (cfg_q.wrap == 32'h0) ? range_max : {1'b0, cfg_q.wrap};   // RULE14 RULE5
  assign delta    = cfg_q.dir ? -17'(signed'(angle - prev_q))
                              : 17'(signed'(angle - prev_q));                   // RULE1
  assign eff_cpt  = cfg_q.scale_en ? 18'(signed'({1'b0, cfg_q.cpt[16:0]}))     // RULE3
                                   : 18'(signed'(RPC_CPT_MAX[17:0]));           // RULE2
  assign frac_sum = 36'(signed'({1'b0, rem_q})) + 36'(delta) * 36'(eff_cpt);  // product kept at full width
  assign step     = frac_sum >>> RPC_NATIVE_BITS;
  assign pos_sum  = 36'(signed'({1'b0, pos_q})) + step;
  // one correction per sample: a step spanning a whole wrap range is folded back only once
  assign pos_fix  = (pos_sum < 0) ? pos_sum + 36'(signed'({1'b0, range_w}))
                  : (pos_sum >= 36'(signed'({1'b0, range_w}))) ? pos_sum - 36'(signed'({1'b0, range_w}))
                  : pos_sum;                                                    // RULE5

  ////////////////////////////////////////////////////////////////////////
  // refresh timer
  logic [31:0] tmr_q;
  wire         tick = conn_up_q && (tmr_q == 32'(RPI_CYCLES - 1));   // RULE11

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      tmr_q <= 32'h0;
    end else begin
      tmr_q <= (!conn_up_q || tick) ? 32'h0 : tmr_q + 32'h1;
    end
  end

  // position tracker, cleared whenever a new configuration arrives
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      prev_q <= 16'h0;
      rem_q  <= 16'h0;
      pos_q  <= 32'h0;
      seen_q <= 1'b0;
    end else if (cfg_wr) begin
      rem_q  <= 16'h0;
      pos_q  <= 32'h0;
      seen_q <= 1'b0;
    end else if (angle_valid) begin
      prev_q <= angle;
      seen_q <= 1'b1;
      if (adv) begin
        rem_q <= frac_sum[15:0];
        pos_q <= pos_fix[31:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // velocity over one refresh interval
  localparam logic signed [63:0] HZ_S  = 64'(RPC_CLK_HZ);
  localparam logic signed [63:0] KHZ_S = 64'(RPC_CLK_HZ / 1000);
  localparam logic signed [63:0] RPI_S = 64'(RPI_CYCLES);
  localparam logic signed [63:0] NAT_S = 64'(RPC_NATIVE_CPT);
  localparam logic signed [63:0] MIN_S = 64'sh3c;  // seconds per minute
  wire signed [31:0] nat_inc = adv ? 32'(delta) : 32'sh0;
  logic signed [63:0] pul_sum;
  logic signed [63:0] v_pps;
  logic signed [63:0] v_ppms;
  logic signed [63:0] v_ppmin;
  logic signed [63:0] v_rpm;
  logic signed [31:0] vel_w;

  // pulse units use the counts-per-turn basis even unscaled, rpm the native counts; signed math truncates to zero
  assign pul_sum = 64'(nat_acc_q) * 64'(signed'({1'b0, cfg_q.cpt})) / NAT_S;                 // RULE4
  assign v_pps   = pul_sum * HZ_S / RPI_S;                                                    // RULE4
  assign v_ppms  = pul_sum * KHZ_S / RPI_S;
  assign v_ppmin = pul_sum * HZ_S * MIN_S / RPI_S;
  assign v_rpm   = 64'(nat_acc_q) * HZ_S * MIN_S / (RPI_S * NAT_S);
  assign vel_w   = (cfg_q.vel_unit == RPC_VU_PPMS)  ? v_ppms[31:0]
                 : (cfg_q.vel_unit == RPC_VU_PPMIN) ? v_ppmin[31:0]
                 : (cfg_q.vel_unit == RPC_VU_RPM)   ? v_rpm[31:0]
                 : v_pps[31:0];                                                              // RULE7

  // accumulators restart each interval without losing the tick's sample
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      nat_acc_q <= 32'sh0;
    end else begin
      nat_acc_q <= (tick || cfg_wr) ? nat_inc : nat_acc_q + nat_inc;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // image emitter
  rpc_state_t  st_q;
  logic [31:0] img_q [RPC_SYNC_WORDS];
  logic [2:0]  idx_q;
  logic [2:0]  nwords_q;
  logic [31:0] vel_q;
  logic        b_ready;
  rpc_word_t   b_in;
  rpc_word_t   b_out;
  logic        b_valid;
  wire         push = (st_q == RPC_SEND) && b_ready;
  wire         lastw = (idx_q == nwords_q - 3'd1);

  assign b_in.data = img_q[idx_q];
  assign b_in.last = lastw;

  // a tick while still sending is skipped, keeping images whole
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st_q     <= RPC_IDLE;
      idx_q    <= 3'h0;
      nwords_q <= 3'h0;
      vel_q    <= 32'h0;
      for (int i = 0; i < RPC_SYNC_WORDS; i++) begin
        img_q[i] <= 32'h0;
      end
    end else begin
      if (tick) begin
        vel_q <= vel_w;
      end
      case (st_q)
        RPC_IDLE: begin
          if (tick) begin
            img_q[0] <= pos_q;                   // RULE12
            img_q[1] <= vel_w;                   // RULE12
            img_q[2] <= sync_data[31:0];
            img_q[3] <= sync_data[63:32];
            img_q[4] <= sync_data[95:64];
            nwords_q <= time_sync_fmt ? 3'(RPC_SYNC_WORDS) : 3'(RPC_PLAIN_WORDS); // RULE8
            idx_q    <= 3'h0;
            st_q     <= RPC_SEND;
          end
        end
        RPC_SEND: begin
          if (push) begin
            idx_q <= idx_q + 3'h1;
            if (lastw) begin
              st_q <= RPC_IDLE;
            end
          end
        end
        default: st_q <= RPC_IDLE;
      endcase
    end
  end

  rpc_buf2 #(
    .WIDTH ($bits(rpc_word_t)),
    .DEPTH (RPC_BUF_DEPTH)
  ) u_buf (
    .mclk      (mclk),
    .rstn      (rstn),
    .in_valid  (st_q == RPC_SEND),
    .in_ready  (b_ready),
    .in_data   (b_in),
    .out_valid (b_valid),
    .out_ready (img_ready),
    .out_data  (b_out)
  );

  assign cfg_ok       = cfg_ok_q;
  assign conn_up      = conn_up_q;
  assign conn_refused = refused_q;
  assign position     = pos_q;
  assign velocity     = vel_q;
  assign img_word     = b_out;
  assign img_valid    = b_valid;

  ////////////////////////////////////////////////////////////////////////
  // checks
  logic [2:0]  beat_q;
  logic [31:0] since_q;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      beat_q  <= 3'h0;
      since_q <= 32'h0;
    end else begin
      if (push) begin
        beat_q <= lastw ? 3'h0 : beat_q + 3'h1;
      end
      since_q <= (tick || !conn_up_q) ? 32'h0 : since_q + 32'h1;  // restarts while the link is down
    end
  end

  AST_CONN_NEEDS_CFG: assert property (@(posedge mclk) disable iff (!rstn) // RULE9
    conn_up_q |-> cfg_ok_q) else $error("link up without valid configuration");
  AST_REFUSE: assert property (@(posedge mclk) disable iff (!rstn) // RULE9
    conn_open && !cfg_ok_q && !conn_up_q |=> refused_q && !conn_up_q)
    else $error("open not refused");
  AST_CFG_RANGES: assert property (@(posedge mclk) disable iff (!rstn) // RULE6
    cfg_ok_q |-> cfg_q.cpt >= RPC_CPT_MIN && cfg_q.cpt <= RPC_CPT_MAX
      && (cfg_q.wrap == 32'h0 || (cfg_q.wrap >= RPC_WRAP_MIN && {1'b0, cfg_q.wrap} <= range_max)))
    else $error("stored configuration out of range");
  AST_POS_WRAP: assert property (@(posedge mclk) disable iff (!rstn) // RULE5
    {1'b0, pos_q} < range_w) else $error("position beyond wrap count");
  AST_NATIVE_RANGE: assert property (@(posedge mclk) disable iff (!rstn) // RULE14
    cfg_q.wrap == 32'h0 |-> range_w == range_max) else $error("zero wrap not native");
  AST_UNSCALED_STEP: assert property (@(posedge mclk) disable iff (!rstn) // RULE2
    adv && !cfg_wr && !cfg_q.scale_en && !cfg_q.dir && (angle == prev_q + 16'h1)
      && ({1'b0, pos_q} + 33'h1 < range_w) |=> pos_q == $past(pos_q) + 32'h1)
    else $error("unscaled step not one count");
  AST_CCW_STEP: assert property (@(posedge mclk) disable iff (!rstn) // RULE1
    adv && !cfg_wr && !cfg_q.scale_en && cfg_q.dir && (angle == prev_q + 16'h1)
      && pos_q != 32'h0 |=> pos_q == $past(pos_q) - 32'h1)
    else $error("reversed direction not counting down");
  AST_REFRESH: assert property (@(posedge mclk) disable iff (!rstn) // RULE11
    tick |-> since_q == 32'(RPI_CYCLES - 1))
    else $error("refresh interval wrong");
  AST_IMG_LEN: assert property (@(posedge mclk) disable iff (!rstn) // RULE8
    push && lastw |-> beat_q == nwords_q - 3'd1
      && (nwords_q == 3'(RPC_PLAIN_WORDS) || nwords_q == 3'(RPC_SYNC_WORDS)))
    else $error("image word count wrong");
  AST_FIRST_POS: assert property (@(posedge mclk) disable iff (!rstn) // RULE12
    st_q == RPC_IDLE && tick |=> img_q[0] == $past(pos_q) && img_q[1] == $past(vel_w))
    else $error("image words misplaced");

  COV_CONN:  cover property (@(posedge mclk) disable iff (!rstn) open_ok ##1 conn_up_q);
  COV_SYNC:  cover property (@(posedge mclk) disable iff (!rstn)
    push && lastw && nwords_q == 3'(RPC_SYNC_WORDS));
  COV_STALL: cover property (@(posedge mclk) disable iff (!rstn) st_q == RPC_SEND && !b_ready);
  COV_WRAP:  cover property (@(posedge mclk) disable iff (!rstn) adv && pos_sum >= 36'(signed'({1'b0, range_w})));
endmodule
`default_nettype wire

// [rtl/rpc_pkg.sv]
// constants and carrier types for the resolver position and image block
package rpc_pkg;
  localparam int unsigned RPC_CLK_HZ      = 50_000_000; // mclk rate
  localparam int unsigned RPC_RPI_MS      = 8;          // default refresh interval, ms
  localparam int unsigned RPC_RPI_CYCLES  = RPC_CLK_HZ / 1000 * RPC_RPI_MS;
  localparam int unsigned RPC_NATIVE_CPT  = 65536;      // native counts per turn
  localparam int unsigned RPC_NATIVE_BITS = 16;
  localparam int unsigned RPC_POS_BITS    = 16;         // single-turn variant
  localparam int unsigned RPC_PLAIN_WORDS = 2;          // 8 bytes
  localparam int unsigned RPC_SYNC_WORDS  = 5;          // 20 bytes
  localparam int unsigned RPC_BUF_DEPTH   = 2;
  localparam logic [15:0] RPC_VU_PPS      = 16'h1f04;
  localparam logic [15:0] RPC_VU_PPMS     = 16'h1f05;
  localparam logic [15:0] RPC_VU_PPMIN    = 16'h1f07;
  localparam logic [15:0] RPC_VU_RPM      = 16'h1f0f;
  localparam logic [31:0] RPC_CPT_MIN     = 32'h0000_0001;
  localparam logic [31:0] RPC_CPT_MAX     = 32'h0001_0000;
  localparam logic [31:0] RPC_WRAP_MIN    = 32'h0000_0002;

  // configuration set pushed by the scanner; zero after reset, which is invalid
  typedef struct packed {
    logic        dir;
    logic        scale_en;
    logic [31:0] cpt;
    logic [31:0] wrap;
    logic [15:0] vel_unit;
  } rpc_cfg_t;

  // one word of the input image
  typedef struct packed {
    logic [31:0] data;
    logic        last;
  } rpc_word_t;

  typedef enum logic [1:0] {
    RPC_IDLE = 2'b00,
    RPC_SEND = 2'b01
  } rpc_state_t;
endpackage

// [rtl/rpc_buf2.sv]
// two-entry shift buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module rpc_buf2
  import rpc_pkg::*;
#(
  parameter int unsigned WIDTH = 33,
  parameter int unsigned DEPTH = RPC_BUF_DEPTH
) (
  input  wire logic             mclk,
  input  wire logic             rstn,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [DEPTH-1:0] v_q;
  logic [DEPTH-1:0] nv;
  wire              pop  = v_q[0] && out_ready;
  wire              push = in_valid && !v_q[DEPTH-1];

  // per entry: shift on pop, take input at first free slot
  for (genvar i = 0; i < DEPTH; i++) begin : g_ent
    wire [WIDTH-1:0] nxt_mem = (i + 1 < DEPTH) ? mem_q[(i + 1) % DEPTH] : mem_q[i];
    wire             nxt_v   = (i + 1 < DEPTH) ? v_q[(i + 1) % DEPTH] : 1'b0;
    wire             prev_v  = (i == 0) ? 1'b1 : nv[(i + DEPTH - 1) % DEPTH];
    assign nv[i] = pop ? nxt_v : v_q[i];
    wire             here    = push && !nv[i] && prev_v;
    always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
        v_q[i]   <= 1'b0;
        mem_q[i] <= '0;
      end else begin
        v_q[i]   <= nv[i] | here;
        mem_q[i] <= here ? in_data : (pop ? nxt_mem : mem_q[i]);
      end
    end
  end

  assign out_valid = v_q[0];
  assign out_data  = mem_q[0];
  assign in_ready  = !v_q[DEPTH-1];

  // a stalled word holds still
  AST_BUF_HOLD: assert property (@(posedge mclk) disable iff (!rstn)
    out_valid && !out_ready |=> out_valid && $stable(out_data))
    else $error("buffer head changed while stalled");
endmodule
`default_nettype wire

// [verif/rpc_scanner.sv]
// scanner model: pushes the configuration on open and takes image words
`timescale 1ns/1ps
`default_nettype none
module rpc_scanner
  import rpc_pkg::*;
(
  input  wire logic      mclk,
  input  wire logic      rstn,
  input  wire logic      slow,
  output var logic       cfg_wr,
  output var rpc_cfg_t   cfg_in,
  output var logic       conn_open,
  output var logic       conn_close,
  input  wire rpc_word_t img_word,
  input  wire logic      img_valid,
  output logic           img_ready
);
  rpc_word_t  rx_q[$];
  logic [3:0] cyc_q;

  // idle request lines; no cyclic output data is ever sent
  initial begin
    cfg_wr = 1'b0;
    cfg_in = '0;
    conn_open = 1'b0;
    conn_close = 1'b0;
  end

  // slow mode takes a word only every other cycle
  assign img_ready = !slow || cyc_q[0];

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cyc_q <= 4'h0;
    end else begin
      cyc_q <= cyc_q + 4'h1;
    end
  end

  // collect the cyclic image as it is refreshed
  always @(posedge mclk) begin
    if (img_valid && img_ready) begin
      rx_q.push_back(img_word);
    end
  end

  // whole set pushed first, open one cycle later
  task automatic open_conn(input rpc_cfg_t c);
    @(posedge mclk);
    cfg_wr <= 1'b1;
    cfg_in <= c;
    @(posedge mclk);
    cfg_wr <= 1'b0;
    conn_open <= 1'b1;
    @(posedge mclk);
    conn_open <= 1'b0;
  endtask

  task automatic close_conn();
    @(posedge mclk);
    conn_close <= 1'b1;
    @(posedge mclk);
    conn_close <= 1'b0;
  endtask
endmodule
`default_nettype wire

// [verif/tb_resolver_position_config.sv]
// testbench for the resolver position and image block
`timescale 1ns/1ps
`default_nettype none
module tb_resolver_position_config
  import rpc_pkg::*;
;
  localparam int unsigned RPI = 64;
  logic        mclk, rstn, slow, time_sync_fmt, angle_valid;
  logic [15:0] angle;
  logic [95:0] sync_data;
  logic        cfg_wr, conn_open, conn_close, cfg_ok, conn_up, conn_refused;
  logic        img_valid, img_ready;
  logic [31:0] position, velocity;
  rpc_cfg_t    cfg_in;
  rpc_word_t   img_word;
  rpc_cfg_t    ctab[7];
  rpc_cfg_t    icfg[5];
  logic        ok[7];
  logic        fmt[5];
  int          a1[5];
  int          n_fail, checks, cyc, nw;
  longint      nat, p, d, r, pe, ve;

  rpc_core #(.POS_BITS(16), .RPI_CYCLES(RPI)) u_dut (
    .mclk(mclk), .rstn(rstn), .cfg_wr(cfg_wr), .cfg_in(cfg_in), .conn_open(conn_open),
    .conn_close(conn_close), .time_sync_fmt(time_sync_fmt), .sync_data(sync_data),
    .angle_valid(angle_valid), .angle(angle), .cfg_ok(cfg_ok), .conn_up(conn_up),
    .conn_refused(conn_refused), .position(position), .velocity(velocity),
    .img_word(img_word), .img_valid(img_valid), .img_ready(img_ready));

  rpc_scanner u_scn (
    .mclk(mclk), .rstn(rstn), .slow(slow), .cfg_wr(cfg_wr), .cfg_in(cfg_in),
    .conn_open(conn_open), .conn_close(conn_close), .img_word(img_word),
    .img_valid(img_valid), .img_ready(img_ready));

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // hang guard
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 4000) begin
      n_fail++;
      wrap_up();
    end
  end

  function automatic rpc_cfg_t mk(logic dr, logic s, logic [31:0] c, logic [31:0] w, logic [15:0] u);
    return '{dr, s, c, w, u};
  endfunction

  // expected velocity for a unit code, interval sums p (turn basis) and n (native)
  function automatic longint vexp(logic [15:0] u, longint pp, longint n);
    longint hz;
    longint rp;
    hz = longint'(RPC_CLK_HZ);
    rp = longint'(RPI);
    case (u)
      RPC_VU_PPMS:  return pp * (hz / 1000) / rp;
      RPC_VU_PPMIN: return pp * hz * 60 / rp;
      RPC_VU_RPM:   return n * hz * 60 / (rp * 65536);
      default:      return pp * hz / rp;
    endcase
  endfunction

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic wrap_up();
    if (n_fail == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // one resolver sample
  task automatic smp(input int a);
    @(posedge mclk);
    angle_valid <= 1'b1;
    angle <= a[15:0];
    @(posedge mclk);
    angle_valid <= 1'b0;
  endtask

  initial begin
    rstn = 1'b0;
    slow = 1'b0;
    time_sync_fmt = 1'b0;
    angle_valid = 1'b0;
    angle = 16'h0000;
    sync_data = 96'h1234_5678_9abc_def0_0f1e_2d3c;
    ctab = '{mk(0, 0, 1, 2, RPC_VU_PPS), mk(0, 0, 0, 0, RPC_VU_PPS), mk(0, 1, 65536, 65536, RPC_VU_RPM),
             mk(0, 0, 65537, 0, RPC_VU_PPS), mk(0, 0, 4096, 1, RPC_VU_PPS),
             mk(0, 0, 4096, 65537, RPC_VU_PPS), mk(1, 0, 4096, 0, 16'h1f06)};
    ok = '{1, 0, 1, 0, 0, 0, 0};
    icfg = '{mk(0, 0, 65536, 0, RPC_VU_PPS), mk(1, 0, 65536, 0, RPC_VU_PPMS), mk(0, 1, 4096, 0, RPC_VU_PPMIN),
             mk(0, 1, 4096, 10, RPC_VU_RPM), mk(0, 0, 4096, 0, RPC_VU_PPS)};
    a1 = '{2, 2, 256, 256, 256};
    fmt = '{0, 1, 0, 0, 0};
    repeat (5) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    #1;
    check("cfg_ok after reset", cfg_ok, 1'b0);
    check("conn_up after reset", conn_up, 1'b0);
    // boundary and out-of-range sets, valid and invalid back to back
    for (int i = 0; i < 7; i++) begin
      u_scn.open_conn(ctab[i]);
      #1;
      check("cfg_ok", cfg_ok, ok[i]);
      check("conn_up", conn_up, ok[i]);
      check("conn_refused", conn_refused, !ok[i]);
    end
    // position and velocity through the cyclic image
    for (int i = 0; i < 5; i++) begin
      slow <= fmt[i];
      time_sync_fmt <= fmt[i];
      u_scn.rx_q.delete();
      u_scn.open_conn(icfg[i]);
      smp(0);
      smp(a1[i] / 2);
      smp(a1[i]);
      nw = fmt[i] ? 5 : 2;
      for (int k = 0; k < 300 && u_scn.rx_q.size() < nw; k++) @(posedge mclk);
      #1;
      nat = icfg[i].dir ? -a1[i] : a1[i];
      p = nat * longint'(icfg[i].cpt) / 65536;
      d = icfg[i].scale_en ? p : nat;
      r = (icfg[i].wrap != 0) ? longint'(icfg[i].wrap) : 65536;
      pe = ((d % r) + r) % r;
      ve = vexp(icfg[i].vel_unit, p, nat);
      check("word count", u_scn.rx_q.size(), nw);
      check("image position", u_scn.rx_q[0].data, pe);
      check("image velocity", u_scn.rx_q[1].data, ve);
      for (int k = 2; k < nw; k++) check("sync word", u_scn.rx_q[k].data, sync_data[32*(k-2) +: 32]);
      for (int k = 0; k < nw; k++) check("last flag", u_scn.rx_q[k].last, k == nw - 1);
      check("position", position, pe);
      check("velocity", velocity, ve);
      u_scn.close_conn();
      repeat (12) @(posedge mclk);
    end
    wrap_up();
  end
endmodule
`default_nettype wire
